// >>> bsel_defs.svh
`ifndef BSEL_DEFS_SVH
`define BSEL_DEFS_SVH

// Core clock rate
`define BSEL_CLK_MHZ       40
// Time the straps get after reset release before capture
`define BSEL_SETTLE_NS     200
// Settle time in core cycles, rounded up; selector raises counts below two to two
`define BSEL_SETTLE_CYC    (((`BSEL_SETTLE_NS * `BSEL_CLK_MHZ) + 999) / 1000)
// Bit positions inside the synchronised strap vector
`define BSEL_POS_EPROM     2
`define BSEL_POS_LINK      1
`define BSEL_POS_SELECT    0
// Reset values of the pin driver
`define BSEL_RST_SEL_OUT   1'h1
`define BSEL_RST_SEL_OE    1'h0
`endif

// >>> bsel_pkg.sv
package bsel_pkg;
  // Decoded boot mode; reserved straps get their own code
  typedef enum logic [2:0] {
    BSEL_MODE_EPROM,
    BSEL_MODE_HOST,
    BSEL_MODE_LINK,
    BSEL_MODE_NO_BOOT,
    BSEL_MODE_RESERVED
  } bsel_mode_type;

  // Strap decode used by the capture logic
  function automatic bsel_mode_type decode_mode(input logic eprom, input logic link,
                                                input logic sel);
    bsel_mode_type m;
    m = BSEL_MODE_RESERVED;
    if (eprom && !link) begin
      m = BSEL_MODE_EPROM;
    end else if (!eprom && !link && sel) begin
      m = BSEL_MODE_HOST;
    end else if (!eprom && link && sel) begin
      m = BSEL_MODE_LINK;
    end else if (!eprom && !link && !sel) begin
      m = BSEL_MODE_NO_BOOT;
    end
    return m;
  endfunction
endpackage

// >>> bsel_sync.sv
// Two-stage synchroniser for pin-level inputs
module bsel_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  // First stage, read only by the second stage
  logic [WIDTH-1:0] meta_r;

  // Both stages clear on reset
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule

// >>> bsel_boot_sel.sv
`include "bsel_defs.svh"

// Boot mode selector: samples the hardwired straps after reset,
// decodes the boot mode once and, in EPROM mode only, drives the boot memory select pin.
module bsel_boot_sel #(
  parameter int SETTLE_CYC = `BSEL_SETTLE_CYC
) (
  input  wire logic               core_clk_i,
  input  wire logic               rst_i,
  input  wire logic               eprom_boot_pin_i,
  input  wire logic               link_boot_pin_i,
  input  wire logic               boot_memory_select_pin_i,
  input  wire logic               eprom_cs_req_i,
  output logic                    boot_memory_select_pin_o,
  output logic                    boot_memory_select_pin_oe_o,
  output bsel_pkg::bsel_mode_type boot_mode_o,
  output logic                    mode_valid_o,
  output logic                    mode_reserved_o
);
  // Capture sequencer states
  typedef enum logic [1:0] {
    BSEL_ST_SETTLE,
    BSEL_ST_CAPTURE,
    BSEL_ST_HOLD
  } bsel_state_type;

  // Capture must wait for both synchroniser stages to fill; a count
  // below two would capture the cleared stages instead of the straps,
  // so small overrides are raised to two.
  localparam int SETTLE_USE = (SETTLE_CYC < 2) ? 2 : SETTLE_CYC;
  // Edges from the first unreset edge until valid is seen high
  localparam int VALID_LAT  = SETTLE_USE + 1;
  // Counter width covers the settle count
  localparam int CNT_W = $clog2(SETTLE_USE + 1);
  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_USE - 1);

  bsel_state_type          state_r;       // Sequencer state
  logic [CNT_W-1:0]        settle_cnt_r;  // Cycles since reset release, held once settle ends
  logic [2:0]              straps_sync;   // Straps after two flops
  logic                    eprom_s;       // Synced EPROM boot strap
  logic                    link_s;        // Synced link boot strap
  logic                    select_s;      // Synced select pin level
  bsel_pkg::bsel_mode_type mode_nxt;      // Decode of current straps

  // Straps are pins, so they cross two flops before any logic
  bsel_sync #(
    .WIDTH (3)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .async_i    ({eprom_boot_pin_i, link_boot_pin_i, boot_memory_select_pin_i}),
    .sync_o     (straps_sync)
  );

  assign eprom_s  = straps_sync[`BSEL_POS_EPROM];
  assign link_s   = straps_sync[`BSEL_POS_LINK];
  assign select_s = straps_sync[`BSEL_POS_SELECT];

  // Combinational decode of the strap table
  always_comb begin
    mode_nxt = bsel_pkg::decode_mode(eprom_s, link_s, select_s);
  end

  // Settle counter: lets the synchroniser fill before capture
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      settle_cnt_r <= '0;
    end else if (state_r == BSEL_ST_SETTLE) begin
      settle_cnt_r <= settle_cnt_r + CNT_W'(1);
    end
  end

  // Sequencer: settle, capture once, then hold until next reset
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= BSEL_ST_SETTLE;
    end else begin
      case (state_r)
        // Wait for straps to propagate after release
        BSEL_ST_SETTLE: begin
          if (settle_cnt_r == SETTLE_LAST) begin
            state_r <= BSEL_ST_CAPTURE;
          end
        end
        // Single capture cycle
        BSEL_ST_CAPTURE: begin
          state_r <= BSEL_ST_HOLD;
        end
        // Only reset leaves this state
        BSEL_ST_HOLD: begin
          state_r <= BSEL_ST_HOLD;
        end
        default: begin
          state_r <= BSEL_ST_SETTLE;
        end
      endcase
    end
  end

  // Mode register: written once, so later strap changes are ignored
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      boot_mode_o     <= bsel_pkg::BSEL_MODE_NO_BOOT;
      mode_valid_o    <= 1'h0;
      mode_reserved_o <= 1'h0;
    end else if (state_r == BSEL_ST_CAPTURE) begin
      boot_mode_o     <= mode_nxt;
      mode_valid_o    <= 1'h1;
      // Reserved straps are flagged, not acted on
      mode_reserved_o <= (mode_nxt == bsel_pkg::BSEL_MODE_RESERVED);
    end
  end

  // Pin direction: the pin is an input until EPROM mode is known,
  // so host, link and no-boot systems never see contention.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      boot_memory_select_pin_oe_o <= `BSEL_RST_SEL_OE;
    end else if (state_r == BSEL_ST_CAPTURE) begin
      boot_memory_select_pin_oe_o <= (mode_nxt == bsel_pkg::BSEL_MODE_EPROM);
    end
  end

  // Active-low EPROM chip select, idles high
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      boot_memory_select_pin_o <= `BSEL_RST_SEL_OUT;
    end else if (boot_memory_select_pin_oe_o) begin
      boot_memory_select_pin_o <= ~eprom_cs_req_i;
    end else begin
      // Parked high so enabling never glitches a select
      boot_memory_select_pin_o <= `BSEL_RST_SEL_OUT;
    end
  end

  // Checks on the design's own outputs
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // Captured straps for the properties below
  sequence s_capture(bit e, bit l, bit s);
    state_r == BSEL_ST_CAPTURE && eprom_s == e && link_s == l && select_s == s;
  endsequence

  a_eprom_mode_drive: assert property (
    state_r == BSEL_ST_CAPTURE && eprom_s && !link_s |=>
      boot_mode_o == bsel_pkg::BSEL_MODE_EPROM && boot_memory_select_pin_oe_o && mode_valid_o)
    else $error("EPROM straps did not give EPROM mode with pin driven");

  a_host_mode_sel: assert property (
    s_capture(1'b0, 1'b0, 1'b1) |=> boot_mode_o == bsel_pkg::BSEL_MODE_HOST)
    else $error("Host straps did not give host mode");

  a_link_mode_sel: assert property (
    s_capture(1'b0, 1'b1, 1'b1) |=> boot_mode_o == bsel_pkg::BSEL_MODE_LINK)
    else $error("Link straps did not give link mode");

  a_no_boot_sel: assert property (
    s_capture(1'b0, 1'b0, 1'b0) |=> boot_mode_o == bsel_pkg::BSEL_MODE_NO_BOOT
      && !mode_reserved_o)
    else $error("All-low straps did not give no-boot mode");

  a_reserved_flag: assert property (
    state_r == BSEL_ST_CAPTURE && eprom_s && link_s |=> mode_reserved_o
      && !boot_memory_select_pin_oe_o)
    else $error("Reserved straps not flagged or pin driven");

  a_pin_dir_mode: assert property (
    boot_memory_select_pin_oe_o == (mode_valid_o && boot_mode_o == bsel_pkg::BSEL_MODE_EPROM))
    else $error("Select pin direction disagrees with mode");

  a_mode_held_const: assert property (
    mode_valid_o |=> $stable(boot_mode_o) && mode_valid_o && $stable(mode_reserved_o))
    else $error("Boot mode changed after capture");

  a_capture_timing: assert property (
    $fell(rst_i) |-> !mode_valid_o [*3])
    else $error("Mode valid too early after reset release");

  a_cs_follows_req: assert property (
    boot_memory_select_pin_oe_o && eprom_cs_req_i |=>
      !boot_memory_select_pin_o || !$past(boot_memory_select_pin_oe_o))
    else $error("Chip select not asserted on request");

  // Select must return high as soon as the core drops its request,
  // or the EPROM would stay enabled onto the shared data bus.
  a_cs_release: assert property (
    boot_memory_select_pin_oe_o && !eprom_cs_req_i |=> boot_memory_select_pin_o)
    else $error("Chip select held without request");

  // While released the driver is parked high, whatever the core asks
  a_cs_park_idle: assert property (
    !boot_memory_select_pin_oe_o |=> boot_memory_select_pin_o)
    else $error("Select driver not parked while released");

  // Low-select link straps are reserved: flagged, pin left released
  a_link_resv_flag: assert property (
    s_capture(1'b0, 1'b1, 1'b0) |=> mode_reserved_o
      && boot_mode_o == bsel_pkg::BSEL_MODE_RESERVED && !boot_memory_select_pin_oe_o)
    else $error("Reserved link straps not flagged");

  // Valid shows exactly one capture after the settle span
  a_valid_latency: assert property (
    $fell(rst_i) |-> ##VALID_LAT mode_valid_o)
    else $error("Mode valid late after reset release");

  // Valid only ever rises out of the capture cycle
  a_valid_only_capture: assert property (
    !mode_valid_o && state_r != BSEL_ST_CAPTURE |=> !mode_valid_o)
    else $error("Mode valid rose outside capture");

  // Main scenarios
  c_eprom_boot: cover property (
    mode_valid_o && boot_mode_o == bsel_pkg::BSEL_MODE_EPROM && !boot_memory_select_pin_o);
  c_host_boot: cover property (mode_valid_o && boot_mode_o == bsel_pkg::BSEL_MODE_HOST);
  c_link_boot: cover property (mode_valid_o && boot_mode_o == bsel_pkg::BSEL_MODE_LINK);
  c_reserved: cover property (mode_valid_o && mode_reserved_o);
  c_no_boot: cover property (mode_valid_o && boot_mode_o == bsel_pkg::BSEL_MODE_NO_BOOT);
endmodule

// >>> bsel_board_model.sv
// Board around the selector: hardwired straps plus the shared select wire
module bsel_board_model (
  input  wire logic eprom_strap_i,   // Strap levels commanded by the bench
  input  wire logic link_strap_i,
  input  wire logic sel_strap_i,     // Resistor level on the select wire
  input  wire logic pin_drv_i,       // Device side of the select pin
  input  wire logic pin_oe_i,
  output logic      eprom_pin_o,
  output logic      link_pin_o,
  output logic      sel_wire_o       // Resolved level seen by both parties
);
  timeunit 1ns;
  timeprecision 1ps;
  // Straps move under reset, bar one deliberate late change; reserved sets on purpose
  assign eprom_pin_o = eprom_strap_i;
  assign link_pin_o  = link_strap_i;
  // Device wins the wire when driving, else the strap resistor sets it
  assign sel_wire_o  = pin_oe_i ? pin_drv_i : sel_strap_i;
endmodule

// >>> bsel_boot_sel_tb.sv
module bsel_boot_sel_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 2;  // Short settle count keeps each boot brief
  logic                    core_clk_i, rst_i, req, e_s, l_s, s_s;
  logic                    e_pin, l_pin, s_wire, pin_o, oe, valid, resv;
  bsel_pkg::bsel_mode_type mode;
  int                      n_mismatch = 0;
  int                      n_compared = 0;
  // Board model feeds the straps and resolves the select wire
  bsel_board_model brd_u (.eprom_strap_i(e_s), .link_strap_i(l_s), .sel_strap_i(s_s),
    .pin_drv_i(pin_o), .pin_oe_i(oe), .eprom_pin_o(e_pin), .link_pin_o(l_pin),
    .sel_wire_o(s_wire));
  bsel_boot_sel #(.SETTLE_CYC(SC)) dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .eprom_boot_pin_i(e_pin), .link_boot_pin_i(l_pin), .boot_memory_select_pin_i(s_wire),
    .eprom_cs_req_i(req), .boot_memory_select_pin_o(pin_o),
    .boot_memory_select_pin_oe_o(oe), .boot_mode_o(mode), .mode_valid_o(valid),
    .mode_reserved_o(resv));
  // Clock at 25 ns
  initial begin
    core_clk_i = 1'h0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  // Single comparison point
  task automatic check(input string what, input logic [2:0] exp, input logic [2:0] seen);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic test_done();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Straps set under reset, then capture timed to the exact edge
  task automatic boot(input logic e, input logic l, input logic s);
    @(posedge core_clk_i);
    rst_i <= 1'h1;
    e_s   <= e;
    l_s   <= l;
    s_s   <= s;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'h0;
    repeat (SC) @(posedge core_clk_i);
    #1 check("valid early", 3'h0, valid);
    @(posedge core_clk_i);
    #1 check("valid", 3'h1, valid);
  endtask
  // Input-mode boots: pin stays released, requests ignored
  task automatic test_inputs();
    @(posedge core_clk_i);
    req <= 1'h1;
    boot(1'h0, 1'h0, 1'h1);
    check("host mode", bsel_pkg::BSEL_MODE_HOST, mode);
    check("host oe", 3'h0, oe);
    check("host pin", 3'h1, pin_o);
    boot(1'h0, 1'h1, 1'h1);
    check("link mode", bsel_pkg::BSEL_MODE_LINK, mode);
    check("link oe", 3'h0, oe);
    check("link pin", 3'h1, pin_o);
    boot(1'h0, 1'h0, 1'h0);
    check("nob mode", bsel_pkg::BSEL_MODE_NO_BOOT, mode);
    check("nob resv", 3'h0, resv);
    check("nob oe", 3'h0, oe);
    @(posedge core_clk_i);
    req <= 1'h0;
    $display("test inputs done");
  endtask
  // EPROM boot: select pin becomes chip select following requests
  task automatic test_eprom();
    boot(1'h1, 1'h0, 1'h0);
    check("eprom mode", bsel_pkg::BSEL_MODE_EPROM, mode);
    check("eprom oe", 3'h1, oe);
    check("cs idle", 3'h1, s_wire);
    check("eprom resv", 3'h0, resv);
    @(posedge core_clk_i);
    req <= 1'h1;
    #1 check("cs not early", 3'h1, s_wire);
    @(posedge core_clk_i);
    #1 check("cs active", 3'h0, s_wire);
    @(posedge core_clk_i);
    req <= 1'h0;
    #1 check("cs held", 3'h0, s_wire);
    @(posedge core_clk_i);
    #1 check("cs release", 3'h1, s_wire);
    $display("test eprom done");
  endtask
  // Reserved straps flagged, and later strap changes never show
  task automatic test_reserved();
    boot(1'h0, 1'h1, 1'h0);
    check("res a mode", bsel_pkg::BSEL_MODE_RESERVED, mode);
    check("res a flag", 3'h1, resv);
    check("res a oe", 3'h0, oe);
    boot(1'h1, 1'h1, 1'h1);
    check("res b mode", bsel_pkg::BSEL_MODE_RESERVED, mode);
    check("res b flag", 3'h1, resv);
    check("res b oe", 3'h0, oe);
    @(posedge core_clk_i);
    e_s <= 1'h1;
    l_s <= 1'h0;
    repeat (8) @(posedge core_clk_i);
    #1 check("held mode", bsel_pkg::BSEL_MODE_RESERVED, mode);
    check("held oe", 3'h0, oe);
    check("held flag", 3'h1, resv);
    $display("test reserved done");
  endtask
  // Main sequence: long first reset, then each scenario
  initial begin
    rst_i = 1'h1;
    req   = 1'h0;
    e_s   = 1'h0;
    l_s   = 1'h0;
    s_s   = 1'h1;
    repeat (20) @(posedge core_clk_i);
    #1 check("reset valid", 3'h0, valid);
    check("reset oe", 3'h0, oe);
    test_inputs();
    test_eprom();
    test_reserved();
    test_done();
  end
  // Watchdog well past the roughly 70 cycles expected
  initial begin
    #50us;
    n_mismatch++;
    test_done();
  end
endmodule
